/* File: core/flash_host.sv */
// Purpose: programmer side of the parallel flash command port
// Assumes: one command at a time; device pins sampled through two flops
// Notes: program and erase run their own verify and retry loops
`timescale 1ns/1ps
module flash_host #(
   parameter int unsigned ERASE_CYC = flash_host_pkg::DE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_cmd_valid,
   input wire flash_host_pkg::cmd_t i_cmd,
   output logic o_cmd_ready,
   output logic o_rsp_valid,
   output flash_host_pkg::rsp_t o_rsp,
   input wire logic [7:0] i_dq,
   output logic [7:0] o_dq,
   output logic o_dq_oe,
   output logic [16:0] o_addr,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic o_vpp_high
);
   flash_host_pkg::ctl_t r;
   flash_host_pkg::ctl_t n;
   flash_host_pkg::act_t act;
   logic t_start;
   logic [flash_host_pkg::TMR_W-1:0] t_cyc;
   logic tmr_busy;
   logic [16:0] a_addr;
   logic [7:0] a_data;
   logic [flash_host_pkg::TMR_W-1:0] a_cyc;
   logic a_pass;
   logic [16:0] pa;
   logic [7:0] pd;
   logic bad_n;

   flash_wait_timer u_timer (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_start(t_start),
      .i_cycles(t_cyc),
      .o_busy(tmr_busy)
   );

   always_comb begin
      n = r;
      act = flash_host_pkg::ACT_NONE;
      t_start = 1'b0;
      t_cyc = '0;
      a_addr = r.caddr;
      a_data = flash_host_pkg::CMD_READ;
      a_cyc = '0;
      a_pass = 1'b0;
      bad_n = r.bad;
      n.rsp_v = 1'b0;
      n.sync1 = i_dq;
      n.sync2 = r.sync1;
      // zero fill reuses the program sequence over the sweep address
      pa = r.fill ? r.sweep : r.caddr;
      pd = r.fill ? flash_host_pkg::ZERO_BYTE : r.cdata;
      unique case (r.st)
         flash_host_pkg::S_IDLE: begin
            if (i_cmd_valid) begin
               n.op = i_cmd.op;
               n.caddr = i_cmd.addr;
               n.cdata = i_cmd.data;
               n.stp = 3'h0;
               n.tries = 5'h00;
               n.bad = 1'b0;
               n.sweep = 17'h00000;
               n.fill = (i_cmd.op == flash_host_pkg::OP_ERASE) && !r.zeroed;
               if (i_cmd.op == flash_host_pkg::OP_PROGRAM &&
                   (i_cmd.addr < flash_host_pkg::PROG_LO ||
                    i_cmd.addr > flash_host_pkg::PROG_HI)) begin
                  n.rsp_v = 1'b1;
                  n.rsp = '{data: 8'h00, pass: 1'b0, refused: 1'b1};
               end else begin
                  n.pins.ce_n = 1'b0;
                  n.st = flash_host_pkg::S_SETUP;
                  t_start = 1'b1;
                  t_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::CS_CYC);
                  // plain read at low supply needs no command cycle
                  if (i_cmd.op == flash_host_pkg::OP_READ && !r.pins.vpp_high) begin
                     n.stp = 3'h2;
                  end
                  if (i_cmd.op != flash_host_pkg::OP_READ && !r.pins.vpp_high) begin
                     n.pins.vpp_high = 1'b1;
                     t_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::VSC_CYC);
                  end
               end
            end
         end
         flash_host_pkg::S_SETUP: begin
            if (!tmr_busy) begin
               n.st = flash_host_pkg::S_DISP;
            end
         end
         flash_host_pkg::S_DISP: begin
            if (r.op == flash_host_pkg::OP_PROGRAM || r.fill) begin
               a_addr = pa;
               case (r.stp)
                  3'h0: begin act = flash_host_pkg::ACT_WR; a_data = flash_host_pkg::CMD_PROGRAM; end
                  3'h1: begin act = flash_host_pkg::ACT_WR; a_data = pd; end
                  3'h2: begin act = flash_host_pkg::ACT_WAIT; a_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::DP_CYC); end
                  3'h3: begin act = flash_host_pkg::ACT_WR; a_data = flash_host_pkg::CMD_PROG_VERIFY; end
                  3'h4: begin act = flash_host_pkg::ACT_WAIT; a_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::WRR_CYC); end
                  3'h5: act = flash_host_pkg::ACT_RD;
                  3'h6: act = flash_host_pkg::ACT_EVAL;
                  default: act = flash_host_pkg::ACT_FIN;
               endcase
            end else if (r.op == flash_host_pkg::OP_ERASE) begin
               a_addr = r.sweep;
               case (r.stp)
                  3'h0: begin act = flash_host_pkg::ACT_WR; a_data = flash_host_pkg::CMD_ERASE; end
                  3'h1: begin act = flash_host_pkg::ACT_WR; a_data = flash_host_pkg::CMD_ERASE; end
                  3'h2: begin act = flash_host_pkg::ACT_WAIT; a_cyc = flash_host_pkg::TMR_W'(ERASE_CYC); end
                  3'h3: begin act = flash_host_pkg::ACT_WR; a_data = flash_host_pkg::CMD_ERASE_VERIFY; end
                  3'h4: begin act = flash_host_pkg::ACT_WAIT; a_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::WRR_CYC); end
                  3'h5: act = flash_host_pkg::ACT_RD;
                  3'h6: act = flash_host_pkg::ACT_EVAL;
                  default: act = flash_host_pkg::ACT_FIN;
               endcase
            end else if (r.op == flash_host_pkg::OP_RESET) begin
               a_data = flash_host_pkg::CMD_RESET;
               a_pass = 1'b1;
               act = (r.stp < 3'h2) ? flash_host_pkg::ACT_WR : flash_host_pkg::ACT_FIN;
            end else begin
               a_data = (r.op == flash_host_pkg::OP_IDENT) ? flash_host_pkg::CMD_IDENT
                                                          : flash_host_pkg::CMD_READ;
               if (r.op == flash_host_pkg::OP_IDENT) begin
                  a_addr = flash_host_pkg::IDENT_ADDR_MAKER | {16'h0000, r.caddr[0]};
               end
               a_pass = 1'b1;
               case (r.stp)
                  3'h0: act = flash_host_pkg::ACT_WR;
                  3'h1: begin act = flash_host_pkg::ACT_WAIT; a_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::WRR_CYC); end
                  3'h2: act = flash_host_pkg::ACT_RD;
                  default: act = flash_host_pkg::ACT_FIN;
               endcase
            end
         end
         flash_host_pkg::S_WCYC: begin
            if (!tmr_busy) begin
               if (!r.ph) begin
                  n.pins.we_n = 1'b1;
                  n.ph = 1'b1;
                  t_start = 1'b1;
                  t_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::WPH_CYC);
               end else begin
                  n.pins.dq_oe = 1'b0;
                  n.ph = 1'b0;
                  n.stp = r.stp + 3'h1;
                  n.st = flash_host_pkg::S_DISP;
               end
            end
         end
         flash_host_pkg::S_RCYC: begin
            if (!tmr_busy) begin
               if (!r.ph) begin
                  n.rd = r.sync2;
                  n.pins.oe_n = 1'b1;
                  n.ph = 1'b1;
                  t_start = 1'b1;
                  t_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::DF_CYC);
               end else begin
                  n.ph = 1'b0;
                  n.stp = r.stp + 3'h1;
                  n.st = flash_host_pkg::S_DISP;
               end
            end
         end
         flash_host_pkg::S_WAIT: begin
            if (!tmr_busy) begin
               n.stp = r.stp + 3'h1;
               n.st = flash_host_pkg::S_DISP;
            end
         end
      endcase

      if (act == flash_host_pkg::ACT_WR) begin
         // address set with the strobe fall, data held past the rise
         n.pins.addr = a_addr;
         n.pins.dq = a_data;
         n.pins.dq_oe = 1'b1;
         n.pins.we_n = 1'b0;
         n.st = flash_host_pkg::S_WCYC;
         t_start = 1'b1;
         t_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::WP_CYC);
      end else if (act == flash_host_pkg::ACT_RD) begin
         n.pins.addr = a_addr;
         n.pins.oe_n = 1'b0;
         n.st = flash_host_pkg::S_RCYC;
         t_start = 1'b1;
         t_cyc = flash_host_pkg::TMR_W'(flash_host_pkg::RD_CYC);
      end else if (act == flash_host_pkg::ACT_WAIT) begin
         n.st = flash_host_pkg::S_WAIT;
         t_start = 1'b1;
         t_cyc = a_cyc;
      end else if (act == flash_host_pkg::ACT_EVAL) begin
         n.stp = 3'h0;
         if (r.op == flash_host_pkg::OP_ERASE && !r.fill) begin
            bad_n = r.bad | (r.rd != flash_host_pkg::ERASED_BYTE);
            n.bad = bad_n;
            if (r.sweep != flash_host_pkg::ARRAY_LAST) begin
               n.sweep = r.sweep + 17'h00001;
               n.stp = 3'h3;
            end else if (!bad_n) begin
               act = flash_host_pkg::ACT_FIN;
               a_pass = 1'b1;
            end
         end else if (r.rd == pd) begin
            n.tries = 5'h00;
            if (!r.fill) begin
               act = flash_host_pkg::ACT_FIN;
               a_pass = 1'b1;
            end else if (r.sweep == flash_host_pkg::ARRAY_LAST) begin
               n.fill = 1'b0;
               n.zeroed = 1'b1;
               n.sweep = 17'h00000;
            end else begin
               n.sweep = r.sweep + 17'h00001;
            end
         end else begin
            bad_n = 1'b1;
         end
         // failed pass: retry the command, only its verify sweep from byte 0 on an erase miss before the last byte, or the current byte in zero fill, until tries run out
         if (act == flash_host_pkg::ACT_EVAL && bad_n) begin
            n.bad = 1'b0;
            n.sweep = r.fill ? r.sweep : 17'h00000;
            if (r.tries == flash_host_pkg::MAX_TRIES - 5'h01) begin
               act = flash_host_pkg::ACT_FIN;
            end else begin
               n.tries = r.tries + 5'h01;
            end
         end
      end
      if (act == flash_host_pkg::ACT_FIN) begin
         n.rsp_v = 1'b1;
         n.rsp = '{data: r.rd, pass: a_pass, refused: 1'b0};
         n.pins.ce_n = 1'b1;
         n.st = flash_host_pkg::S_IDLE;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= flash_host_pkg::CTL_RESET;
      end else begin
         r <= n;
      end
   end

   assign o_cmd_ready = (r.st == flash_host_pkg::S_IDLE);
   assign o_rsp_valid = r.rsp_v;
   assign o_rsp = r.rsp;
   assign o_dq = r.pins.dq;
   assign o_dq_oe = r.pins.dq_oe;
   assign o_addr = r.pins.addr;
   assign o_ce_n = r.pins.ce_n;
   assign o_oe_n = r.pins.oe_n;
   assign o_we_n = r.pins.we_n;
   assign o_vpp_high = r.pins.vpp_high;

   // assertion helpers: strobe low width and last byte written
   logic [7:0] low_cnt;
   logic [7:0] wr_byte;
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         low_cnt <= 8'h00;
         wr_byte <= 8'h00;
      end else begin
         low_cnt <= o_we_n ? 8'h00 : low_cnt + 8'h01;
         if (!o_we_n) begin
            wr_byte <= o_dq;
         end
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   a_we_needs_vpp: assert property (!o_we_n |-> o_vpp_high)
      else $error("write strobe at low supply");
   a_write_state: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
      else $error("write strobe outside write state");
   a_strobe_hold: assert property ($past(!o_we_n) && !o_we_n |-> $stable(o_addr) && $stable(o_dq))
      else $error("address or data moved under strobe");
   a_strobe_width: assert property ($rose(o_we_n) |-> $past(low_cnt) >= 8'(flash_host_pkg::WP_CYC))
      else $error("write strobe too short");
   a_no_contend: assert property (o_dq_oe |-> o_oe_n)
      else $error("bus driven while output enabled");
   a_read_state: assert property ($fell(o_oe_n) |-> !o_ce_n && o_we_n ##1 !o_oe_n [*8])
      else $error("read strobe malformed");
   a_verify_cmd: assert property ($fell(o_oe_n) && (r.op == flash_host_pkg::OP_PROGRAM || r.fill)
      |-> wr_byte == flash_host_pkg::CMD_PROG_VERIFY)
      else $error("program read not preceded by verify");
   a_erase_pair: assert property ($fell(o_we_n) && r.op == flash_host_pkg::OP_ERASE && !r.fill
      && r.stp == 3'h1 |-> o_dq == flash_host_pkg::CMD_ERASE && wr_byte == flash_host_pkg::CMD_ERASE)
      else $error("erase second cycle wrong");
   a_prog_range: assert property (r.op == flash_host_pkg::OP_PROGRAM && !r.fill && !o_we_n
      |-> o_addr >= flash_host_pkg::PROG_LO && o_addr <= flash_host_pkg::PROG_HI)
      else $error("program outside allowed range");
   // a command taken in the answer cycle legally drops ready, so it is excluded
   a_rsp_pulse: assert property (o_rsp_valid && !i_cmd_valid |=> !o_rsp_valid && o_cmd_ready)
      else $error("response not a single pulse");

   c_prog_pass: cover property (o_rsp_valid && o_rsp.pass && r.op == flash_host_pkg::OP_PROGRAM);
   c_erase_done: cover property (o_rsp_valid && r.op == flash_host_pkg::OP_ERASE);
   c_ident_read: cover property (o_rsp_valid && r.op == flash_host_pkg::OP_IDENT);
   c_reset_done: cover property (o_rsp_valid && r.op == flash_host_pkg::OP_RESET);
endmodule : flash_host

/* File: inc/flash_host_pkg.sv */
// Purpose: shared types and constants for the parallel flash programmer port
// Assumes: 200 MHz core clock, byte-wide array with 17 address bits
// Notes: cycle counts are timing minimums rounded up to whole clocks; the read count adds SYNC_CYC plus one more
package flash_host_pkg;
   localparam int CLK_NS = 5;
   localparam int T_WP_NS = 60;
   localparam int T_WPH_NS = 20;
   localparam int T_CS_NS = 20;
   localparam int T_ACC_NS = 150;
   localparam int T_DF_NS = 35;
   localparam int T_WRR_NS = 6000;
   localparam int T_DP_NS = 10000;
   localparam int T_VSC_NS = 1000;
   // 9.5 ms erase time
   localparam int T_DE_NS = 9500000;
   localparam int SYNC_CYC = 2;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CS_CYC = (T_CS_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
   localparam int DF_CYC = (T_DF_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRR_CYC = (T_WRR_NS + CLK_NS - 1) / CLK_NS;
   localparam int DP_CYC = (T_DP_NS + CLK_NS - 1) / CLK_NS;
   localparam int VSC_CYC = (T_VSC_NS + CLK_NS - 1) / CLK_NS;
   localparam int DE_CYC = (T_DE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W = 21;

   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [16:0] PROG_LO = 17'h01000;
   localparam logic [16:0] PROG_HI = 17'h1EFFF;
   localparam logic [16:0] ARRAY_LAST = 17'h1FFFF;
   localparam logic [16:0] IDENT_ADDR_MAKER = 17'h00000;
   localparam logic [4:0] MAX_TRIES = 5'h19;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_SETUP = 6'h02, S_DISP = 6'h04,
      S_WCYC = 6'h08, S_RCYC = 6'h10, S_WAIT = 6'h20
   } state_t;
   typedef enum logic [2:0] {
      OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2, OP_RESET = 3'h3, OP_IDENT = 3'h4
   } op_t;
   typedef enum logic [2:0] {
      ACT_NONE = 3'h0, ACT_WR = 3'h1, ACT_RD = 3'h2, ACT_WAIT = 3'h3, ACT_EVAL = 3'h4,
      ACT_FIN = 3'h5
   } act_t;

   typedef struct packed {
      op_t op;
      logic [16:0] addr;
      logic [7:0] data;
   } cmd_t;
   typedef struct packed {
      logic [7:0] data;
      logic pass;
      logic refused;
   } rsp_t;
   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic vpp_high;
   } pins_t;
   typedef struct packed {
      state_t st;
      op_t op;
      logic [2:0] stp;
      logic ph;
      logic fill;
      logic zeroed;
      logic bad;
      logic [4:0] tries;
      logic [16:0] caddr;
      logic [7:0] cdata;
      logic [16:0] sweep;
      logic [7:0] rd;
      logic [7:0] sync1;
      logic [7:0] sync2;
      pins_t pins;
      logic rsp_v;
      rsp_t rsp;
   } ctl_t;
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
   } tmr_t;

   localparam pins_t PINS_IDLE = '{addr: 17'h00000, dq: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                                   oe_n: 1'b1, we_n: 1'b1, vpp_high: 1'b0};
   localparam ctl_t CTL_RESET = '{st: S_IDLE, op: OP_READ, pins: PINS_IDLE, default: '0};
endpackage : flash_host_pkg

/* File: core/flash_wait_timer.sv */
// Purpose: down counter that holds busy for a loaded number of cycles
// Assumes: load and count share the core clock
// Notes: a load while busy restarts the count
`timescale 1ns/1ps
module flash_wait_timer (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic [flash_host_pkg::TMR_W-1:0] i_cycles,
   output logic o_busy
);
   flash_host_pkg::tmr_t r;
   flash_host_pkg::tmr_t n;

   always_comb begin
      n = r;
      if (i_start) begin
         n.cnt = i_cycles;
      end else if (r.cnt != '0) begin
         n.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_busy = (r.cnt != '0);
endmodule : flash_wait_timer

/* File: bench/flash_device_model.sv */
// Purpose: behavioural flash array answering the host's parallel strobes
// Assumes: strobe-edge driven, no clock; answers reads at once
// Notes: the first WEAK_TRIES program pulses are dropped to force a retry
`timescale 1ns/1ps
module flash_device_model #(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h5C, // arbitrary value
   parameter int WEAK_TRIES = 1
) (
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_dq,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_vpp_high,
   output logic [7:0] o_dq,
   output logic o_dq_oe
);
   logic [7:0] mem [0:131071];
   logic [7:0] cmd_r;
   logic [7:0] rd;
   logic [7:0] last_r;
   logic [16:0] wa_r;
   logic [16:0] pa_r;
   logic [16:0] ea_r;
   int weak_r;
   initial begin
      for (int i = 0; i < 131072; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
      cmd_r = 8'h00;
      weak_r = WEAK_TRIES;
      last_r = 8'h00;
   end
   always @(negedge i_we_n) if (!i_ce_n && i_vpp_high) wa_r = i_addr;
   always @(posedge i_we_n) begin
      // write cycles only count at high supply
      if (!i_ce_n && i_vpp_high) begin
         if (cmd_r == 8'hFF && i_dq == 8'hFF) cmd_r = 8'h00;
         else if ((cmd_r == 8'h40 || cmd_r == 8'h20) && i_dq == 8'hFF) cmd_r = 8'hFF;
         else if (cmd_r == 8'h40) begin
            pa_r = wa_r;
            if (weak_r > 0) weak_r--;
            else mem[wa_r] = i_dq;
            cmd_r = 8'h01;
         end else if (cmd_r == 8'h20 && i_dq == 8'h20) begin
            for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
            cmd_r = 8'h01;
         end else begin
            cmd_r = i_dq;
            if (i_dq == 8'hA0) ea_r = wa_r;
         end
      end
   end
   always @* begin
      if (!i_vpp_high) rd = mem[i_addr];
      else if (cmd_r == 8'hC0) rd = mem[pa_r];
      else if (cmd_r == 8'hA0) rd = mem[ea_r];
      else if (cmd_r == 8'h90) rd = i_addr[0] ? DEVICE_CODE : MAKER_CODE;
      else rd = mem[i_addr];
      o_dq_oe = !i_ce_n && !i_oe_n && i_we_n;
      if (o_dq_oe) last_r = rd;
      // floating pins show a flipped stale byte, never the real one
      o_dq = o_dq_oe ? rd : ~last_r;
   end
endmodule : flash_device_model

/* File: bench/test_flash_host.sv */
// Purpose: self-checking bench for the flash host against a device model
// Assumes: 200 MHz clock, short erase count
// Notes: erase is cut by a mid-run reset once its zero fill has written its second byte; a full sweep is too long
`timescale 1ns/1ps
module test_flash_host;
   localparam logic [7:0] MAKER = 8'hA5; // arbitrary value
   localparam logic [7:0] DEVICE = 8'h5C; // arbitrary value
   logic i_core_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   flash_host_pkg::cmd_t cmd = '0;
   flash_host_pkg::rsp_t rsp;
   flash_host_pkg::rsp_t got;
   logic cmd_ready, rsp_valid, dq_oe, ce_n, oe_n, we_n, vpp_high, dev_oe;
   logic [7:0] host_dq;
   logic [7:0] dev_dq;
   logic [7:0] bus_dq;
   logic [16:0] addr;
   int bad_count = 0;
   int compares = 0;
   int ce_falls = 0;
   int prog_codes = 0;
   assign bus_dq = dq_oe ? host_dq : dev_dq;
   always #2.5 i_core_clk = ~i_core_clk;
   always @(negedge ce_n) ce_falls++;
   always @(posedge we_n) if (host_dq == 8'h40) prog_codes++;
   // host and device must never drive the data pins together
   always @(negedge i_core_clk) if (i_arst_n) check("contend", 1'b0, dq_oe & dev_oe);
   flash_host #(.ERASE_CYC(20)) u_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
      .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
      .o_rsp(rsp), .i_dq(bus_dq), .o_dq(host_dq), .o_dq_oe(dq_oe), .o_addr(addr),
      .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_vpp_high(vpp_high));
   flash_device_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .WEAK_TRIES(1)) u_dev (
      .i_addr(addr), .i_dq(bus_dq), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_vpp_high(vpp_high), .o_dq(dev_dq), .o_dq_oe(dev_oe));
   task automatic conclude();
      if (bad_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   function automatic logic [7:0] pat(input logic [16:0] a);
      return a[7:0] ^ a[15:8];
   endfunction : pat
   task automatic run_cmd(input flash_host_pkg::op_t op, input logic [16:0] a,
                          input logic [7:0] d);
      int n;
      @(posedge i_core_clk);
      cmd <= '{op: op, addr: a, data: d};
      cmd_valid <= 1'b1;
      @(negedge i_core_clk);
      check("ready", 1, cmd_ready);
      @(posedge i_core_clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge i_core_clk);
         n++;
         if (n > 20000) begin
            bad_count++;
            conclude();
         end
      end while (rsp_valid !== 1'b1);
      got = rsp;
   endtask : run_cmd
   task automatic t_idle();
      check("ce_n", 1, ce_n);
      check("oe_n", 1, oe_n);
      check("we_n", 1, we_n);
      check("dq_oe", 0, dq_oe);
      check("vpp", 0, vpp_high);
   endtask : t_idle
   task automatic t_read_low();
      // back-to-back reads before any supply raise
      run_cmd(flash_host_pkg::OP_READ, 17'h12345, 8'h00);
      check("rd0", pat(17'h12345), got.data);
      run_cmd(flash_host_pkg::OP_READ, 17'h0ABCD, 8'h00);
      check("rd1", pat(17'h0ABCD), got.data);
      check("pass", 1, got.pass);
      check("vpp", 0, vpp_high);
   endtask : t_read_low
   task automatic t_refuse();
      logic [16:0] bad_addr [2];
      int f;
      bad_addr = '{17'h00FFF, 17'h1F000};
      foreach (bad_addr[i]) begin
         f = ce_falls;
         run_cmd(flash_host_pkg::OP_PROGRAM, bad_addr[i], 8'h12);
         check("refused", 1, got.refused);
         check("pins", f, ce_falls);
      end
   endtask : t_refuse
   task automatic t_ident();
      run_cmd(flash_host_pkg::OP_IDENT, 17'h00000, 8'h00);
      check("maker", MAKER, got.data);
      check("vpp", 1, vpp_high);
      run_cmd(flash_host_pkg::OP_IDENT, 17'h00001, 8'h00);
      check("device", DEVICE, got.data);
   endtask : t_ident
   task automatic t_program();
      int p;
      p = prog_codes;
      // first pulse is dropped by the model, so a retry is required
      run_cmd(flash_host_pkg::OP_PROGRAM, 17'h01000, 8'h3C);
      check("pass", 1, got.pass);
      check("vfy", 8'h3C, got.data);
      check("tries", 2, prog_codes - p);
      run_cmd(flash_host_pkg::OP_READ, 17'h01000, 8'h00);
      check("rd", 8'h3C, got.data);
      run_cmd(flash_host_pkg::OP_READ, 17'h01001, 8'h00);
      check("nbr", pat(17'h01001), got.data);
      p = prog_codes;
      run_cmd(flash_host_pkg::OP_PROGRAM, 17'h1EFFF, 8'hC3);
      check("top", 8'hC3, got.data);
      check("once", 1, prog_codes - p);
   endtask : t_program
   task automatic t_reset_op();
      run_cmd(flash_host_pkg::OP_RESET, 17'h00000, 8'h00);
      check("pass", 1, got.pass);
      run_cmd(flash_host_pkg::OP_READ, 17'h01000, 8'h00);
      check("kept", 8'h3C, got.data);
   endtask : t_reset_op
   task automatic t_erase_cut();
      int n;
      int p;
      p = prog_codes;
      @(posedge i_core_clk);
      cmd <= '{op: flash_host_pkg::OP_ERASE, addr: 17'h00000, data: 8'h00};
      cmd_valid <= 1'b1;
      @(posedge i_core_clk);
      cmd_valid <= 1'b0;
      n = 0;
      // stop once the zero fill has landed its second byte
      while (u_dev.mem[1] !== 8'h00 && n < 8000) begin
         @(negedge i_core_clk);
         n++;
      end
      if (n >= 8000) begin
         bad_count++;
         conclude();
      end
      check("fill", 2, prog_codes - p);
      @(posedge i_core_clk);
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      t_idle();
      i_arst_n <= 1'b1;
      run_cmd(flash_host_pkg::OP_READ, 17'h00001, 8'h00);
      check("zero", 8'h00, got.data);
      run_cmd(flash_host_pkg::OP_READ, 17'h01000, 8'h00);
      check("after_cut", 8'h3C, got.data);
   endtask : t_erase_cut
   initial begin
      repeat (12) @(posedge i_core_clk);
      t_idle();
      i_arst_n <= 1'b1;
      t_read_low();
      t_refuse();
      t_ident();
      t_program();
      t_reset_op();
      t_erase_cut();
      conclude();
   end
endmodule : test_flash_host
